//--- rsw_core_model.sv
/*
  rsw_core_model: stands in for the core running firmware restarts.
  Assumes it shares sys_clk with the block.
*/
`timescale 1ns/100ps
`default_nettype none
module rsw_core_model (
  input  wire logic sys_clk,
  input  wire logic keep_alive,  // firmware services the dog
  output logic      dog_restart  // restart instruction pulse
);
  logic [9:0] gap_reg;  // restart spacing, well inside one timeout
  // ----------------------------------------
  // periodic restart, one cycle wide
  // ----------------------------------------
  initial begin
    gap_reg = 10'h000;
    dog_restart = 1'b0;
  end
  always @(posedge sys_clk) begin
    gap_reg <= gap_reg + 10'h001;
    dog_restart <= keep_alive && (gap_reg == 10'h3FF);
  end
endmodule : rsw_core_model
`default_nettype wire

//--- rsw_min_width.sv
/*
  rsw_min_width: passes a synchronised level only after it has stood for
  a minimum number of clock cycles; drops it at once when it goes away.
  Assumes level_in is already synchronised to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rsw_min_width
  import rsw_pkg::*;
#(
  parameter logic [FILT_W-1:0] MIN_CYC = 16'h0001
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic level_in,
  output logic      held_out
);
  rsw_filt_t s_reg;     // filter state
  rsw_filt_t s_next;

  // ------------------------------------------------------------
  // width qualification
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (!rst_n) begin
      s_next = '0;
    end else if (!level_in) begin
      s_next = '0;                               // short pulses die here
    end else if (s_reg.cnt >= MIN_CYC - 1'b1) begin
      s_next.held = 1'b1;                        // stood long enough
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  assign held_out = s_reg.held;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_drop_at_once: assert property (!level_in |=> !held_out)
    else $error("filter output outlived its input");
endmodule : rsw_min_width
`default_nettype wire

//--- rsw_pkg.sv
/*
  rsw_pkg: constants, field layouts, state types and bus carriers shared by
  the reset-source and watchdog block and its pulse-width filter.
  Assumes a single 50 MHz system clock and a synchronous active-low reset.
*/
// How it works
// - five reset sources merge into system reset
// - long low pin pulse resets, short ignored
// - pin release: stretch reset for startup delay
// - power-on: stretch on rise, immediate reassert
// - brownout: reset at once, stretch on recovery
// - brownout dips shorter than minimum are ignored
// - watchdog reset pulse lasts one clock cycle
// - enabled bus reset resets core, function stays
// - watchdog counts dedicated 128 kHz oscillator
// - timeouts selectable from 16ms to 8s
// - early warning at first timeout if enabled
// - action at twice the timeout without restart
// - restart instruction clears the watchdog counter
// - interrupt mode: interrupt after double expiry, wakes
// - reset mode: reset after double expiry
// - combined mode: interrupt first, then reset mode
// - fuse forces reset mode, enables locked
// - protected change only within four cycles
// - change bit self-clears when window ends
// - odd clock divider 1, 3, 5, 7 before prescaler
// - divider write also needs unlock; enable stays set
// - vector or write-one clears interrupt flag
// - combined mode vector clears enable and flag
// - dog reset flag forces reset enable set
package rsw_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int SYS_HZ          = 50_000_000;
  localparam int CLK_NS          = 20;
  localparam int OSC_HZ          = 128_000;       // watchdog oscillator
  localparam int BASE_MS         = 16;            // shortest timeout
  localparam int BASE_CYC        = OSC_HZ * BASE_MS / 1000;
  localparam int EXT_MIN_NS      = 2500;          // pin minimum pulse
  localparam int BROWN_MIN_NS    = 2000;          // brownout minimum dip
  localparam int EXT_MIN_CYC     = (EXT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BROWN_MIN_CYC   = (BROWN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_US      = 4100;          // startup delay period
  localparam int STARTUP_CYC_DEF = STARTUP_US * (SYS_HZ / 1_000_000);
  localparam int CNT_W           = 21;            // holds 2 x 8 s of ticks
  localparam int DLY_W           = 24;
  localparam int FILT_W          = 16;
  localparam logic [3:0] PRESC_MAX  = 4'h9;       // 16ms << 9 = 8 s
  localparam logic [2:0] UNLOCK_CYC = 3'h4;
  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_CKD_OFS  = 4'h4;
  localparam logic [3:0] REG_FLAG_OFS = 4'h8;
  localparam int CTL_IRQ_FLAG = 7;
  localparam int CTL_IRQ_EN   = 6;
  localparam int CTL_PRESC3   = 5;
  localparam int CTL_UNLOCK   = 4;
  localparam int CTL_SRST_EN  = 3;
  localparam int CKD_EW_EN    = 2;
  localparam int CKD_EW_FLAG  = 3;
  localparam int FLG_POR      = 0;
  localparam int FLG_EXT      = 1;
  localparam int FLG_BROWN    = 2;
  localparam int FLG_DOG      = 3;
  localparam int FLG_USB      = 5;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSW_SEQ_HOLD    = 2'b00,
    RSW_SEQ_STRETCH = 2'b01,
    RSW_SEQ_RUN     = 2'b11
  } rsw_seq_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } rsw_avs_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } rsw_avs_rsp_t;

  typedef struct packed {
    logic [1:0]       pin_sy;      // [0] first stage, [1] second
    logic [1:0]       por_sy;
    logic [1:0]       brown_sy;
    logic [1:0]       osc_sy;
    logic             osc_last;
    logic [2:0]       div_cnt;
    logic [CNT_W-1:0] dog_cnt;
    logic [2:0]       unlock_cnt;
    logic             irq_flag;
    logic             irq_en;
    logic             srst_en;
    logic [3:0]       presc;
    logic [1:0]       div_sel;
    logic             ew_en;
    logic             ew_flag;
    logic [5:0]       rst_flags;
    logic             dog_pulse;
    rsw_seq_t         seq;
    logic [DLY_W-1:0] dly_cnt;
    logic             sys_reset;
    logic             irq_req;
    logic             ew_req;
    logic             waitreq;
    logic [31:0]      rdata;
  } rsw_state_t;

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic              held;
  } rsw_filt_t;
endpackage : rsw_pkg

//--- rsw_top.sv
/*
  rsw_top: reset-source combiner with startup stretching and a watchdog
  with early warning, interrupt and reset modes, reached over Avalon-MM.
  Assumes pin, supply comparator and oscillator inputs are asynchronous;
  restart, vector and bus-reset inputs come from logic on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rsw_top
  import rsw_pkg::*;
#(
  parameter int STARTUP_CYC = STARTUP_CYC_DEF      // shorten for simulation
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire rsw_avs_req_t  avs_req,             // avalon request group
  output rsw_avs_rsp_t       avs_rsp,             // avalon answer group
  input  wire logic          ext_reset_pin_n,     // external reset pin
  input  wire logic          power_on_below,      // supply under power_on_threshold
  input  wire logic          brownout_below,      // supply under brownout_threshold
  input  wire logic          brownout_enable,     // from brownout_level_fuses
  input  wire logic          always_on_fuse,      // programmed = 1
  input  wire logic          osc_128k,            // dedicated watchdog oscillator
  input  wire logic          dog_restart,         // restart instruction pulse
  input  wire logic          dog_vector_ack,      // interrupt vector taken pulse
  input  wire logic          usb_enable,          // usb function enabled
  input  wire logic          usb_reset_mcu_en,    // reset-the-core option
  input  wire logic          usb_bus_reset,       // valid bus reset detected
  output logic               sys_reset_out,       // stretched system reset
  output logic               dog_irq,             // interrupt, also wake request
  output logic               early_irq            // early-warning interrupt
);
  rsw_state_t s_reg;                               // all block state
  rsw_state_t s_next;
  logic       ext_long;                            // pin low long enough
  logic       brown_long;                          // dip long enough

  // ------------------------------------------------------------
  // width filters for pin and brownout comparator
  // ------------------------------------------------------------
  rsw_min_width #(
    .MIN_CYC (FILT_W'(EXT_MIN_CYC))
  ) u_ext_filt (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .level_in (~s_reg.pin_sy[1]),
    .held_out (ext_long)
  );

  rsw_min_width #(
    .MIN_CYC (FILT_W'(BROWN_MIN_CYC))
  ) u_brown_filt (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .level_in (s_reg.brown_sy[1] & brownout_enable),
    .held_out (brown_long)
  );

  // ------------------------------------------------------------
  // decoded terms shared by the next-state logic and checks
  // ------------------------------------------------------------
  logic             srst_eff;    // reset enable as seen
  logic             irq_eff;     // interrupt enable as seen
  logic             running;     // watchdog not stopped
  logic             osc_edge;    // rising oscillator edge
  logic             div_tick;    // tick after odd divider
  logic [3:0]       presc_c;     // clamped prescale select
  logic [CNT_W-1:0] tmo;         // one timeout in ticks
  logic [CNT_W:0]   tmo2;        // double timeout
  logic             early_hit;   // first timeout reached
  logic             expire;      // double timeout reached
  logic             usb_src;     // qualified bus reset
  logic             por_src;     // power-on condition
  logic             any_src;     // any reset source active
  logic             take;        // bus access completes now
  logic             unlock_now;  // change window open
  logic             wr_ctrl;
  logic             wr_ckd;
  logic             wr_flag;
  logic             unlock_wr;
  logic [31:0]      d;

  always_comb begin
    d          = avs_req.writedata;
    take       = (avs_req.read | avs_req.write) & ~s_reg.waitreq;
    wr_ctrl    = take & avs_req.write & (avs_req.address == REG_CTRL_OFS);
    wr_ckd     = take & avs_req.write & (avs_req.address == REG_CKD_OFS);
    wr_flag    = take & avs_req.write & (avs_req.address == REG_FLAG_OFS);
    unlock_wr  = wr_ctrl & d[CTL_UNLOCK] & d[CTL_SRST_EN];
    unlock_now = (s_reg.unlock_cnt != 3'h0);
    // dog flag and fuse both hold reset enable on
    srst_eff   = s_reg.srst_en | s_reg.rst_flags[FLG_DOG] | always_on_fuse;
    irq_eff    = s_reg.irq_en & ~always_on_fuse;
    running    = srst_eff | irq_eff;
    osc_edge   = s_reg.osc_sy[1] & ~s_reg.osc_last;
    // divide by 1, 3, 5 or 7: last count is twice the select
    div_tick   = osc_edge & (s_reg.div_cnt == {s_reg.div_sel, 1'b0});
    presc_c    = (s_reg.presc > PRESC_MAX) ? PRESC_MAX : s_reg.presc;
    tmo        = CNT_W'(BASE_CYC) << presc_c;
    tmo2       = {tmo, 1'b0};
    early_hit  = div_tick & ({1'b0, s_reg.dog_cnt} == {1'b0, tmo} - 1'b1);
    expire     = div_tick & ({1'b0, s_reg.dog_cnt} == tmo2 - 1'b1);
    usb_src    = usb_enable & usb_reset_mcu_en & usb_bus_reset;
    por_src    = s_reg.por_sy[1];
    any_src    = por_src | ext_long | brown_long | s_reg.dog_pulse | usb_src;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // input synchronisers; only the second stage is read
    s_next.pin_sy   = {s_reg.pin_sy[0], ext_reset_pin_n};
    s_next.por_sy   = {s_reg.por_sy[0], power_on_below};
    s_next.brown_sy = {s_reg.brown_sy[0], brownout_below};
    s_next.osc_sy   = {s_reg.osc_sy[0], osc_128k};
    s_next.osc_last = s_reg.osc_sy[1];
    s_next.dog_pulse = 1'b0;                         // never longer than a cycle

    // odd clock divider on the oscillator
    if (div_tick) begin
      s_next.div_cnt = 3'h0;
    end else if (osc_edge) begin
      s_next.div_cnt = s_reg.div_cnt + 3'h1;
    end

    // watchdog counter: restart and stopped both clear it
    if (dog_restart || !running) begin
      s_next.dog_cnt = '0;
    end else if (expire) begin
      s_next.dog_cnt = '0;
    end else if (div_tick) begin
      s_next.dog_cnt = s_reg.dog_cnt + 1'b1;
    end

    // early warning at the first timeout
    if (running && !dog_restart && early_hit && s_reg.ew_en) begin
      s_next.ew_flag = 1'b1;
    end

    // double timeout: interrupt if enabled and not pending, else reset if reset enabled
    if (running && !dog_restart && expire) begin
      if (irq_eff && !s_reg.irq_flag) begin
        s_next.irq_flag = 1'b1;
      end else if (srst_eff) begin
        s_next.dog_pulse = 1'b1;
      end
    end

    // vector execution clears the flag; combined mode drops to reset mode
    if (dog_vector_ack && !(running && expire)) begin
      s_next.irq_flag = 1'b0;
      if (s_reg.srst_en) begin
        s_next.irq_en = 1'b0;
      end
    end

    // change window countdown; the change bit reads from it
    if (unlock_now) begin
      s_next.unlock_cnt = s_reg.unlock_cnt - 3'h1;
    end

    // control register write
    if (unlock_wr) begin
      s_next.unlock_cnt = UNLOCK_CYC;
      s_next.srst_en    = 1'b1;
      s_next.irq_en     = d[CTL_IRQ_EN];
    end else if (wr_ctrl) begin
      s_next.irq_en = d[CTL_IRQ_EN];
      if (d[CTL_SRST_EN]) begin
        s_next.srst_en = 1'b1;                       // setting needs no unlock
      end else if (unlock_now && !s_reg.rst_flags[FLG_DOG]) begin
        s_next.srst_en = 1'b0;
      end
      if (unlock_now) begin
        s_next.presc = {d[CTL_PRESC3], d[2:0]};
      end
    end
    // write-one clear loses to a same-cycle set
    if (wr_ctrl && d[CTL_IRQ_FLAG] && !(running && expire && irq_eff)) begin
      s_next.irq_flag = 1'b0;
    end

    // divider register: select is guarded, reset enable is left set
    if (wr_ckd) begin
      if (unlock_now) begin
        s_next.div_sel = d[1:0];
      end
      s_next.ew_en = d[CKD_EW_EN];
      if (d[CKD_EW_FLAG] && !(early_hit && s_reg.ew_en)) begin
        s_next.ew_flag = 1'b0;
      end
    end

    // fuse locks the enables
    if (always_on_fuse) begin
      s_next.srst_en = 1'b1;
      s_next.irq_en  = 1'b0;
    end

    // reset-source flags: write zero clears, sets win
    if (wr_flag) begin
      s_next.rst_flags = s_reg.rst_flags & d[5:0];
    end
    if (por_src) begin
      s_next.rst_flags = '0;
      s_next.rst_flags[FLG_POR] = 1'b1;
    end
    if (ext_long)        s_next.rst_flags[FLG_EXT]   = 1'b1;
    if (brown_long)      s_next.rst_flags[FLG_BROWN] = 1'b1;
    if (s_reg.dog_pulse) s_next.rst_flags[FLG_DOG]   = 1'b1;
    if (usb_src)         s_next.rst_flags[FLG_USB]   = 1'b1;

    // reset sequencer: hold while any source, then stretch
    case (s_reg.seq)
      RSW_SEQ_HOLD: begin
        s_next.dly_cnt = '0;
        if (!any_src) begin
          s_next.seq = RSW_SEQ_STRETCH;
        end
      end
      RSW_SEQ_STRETCH: begin
        if (any_src) begin
          s_next.seq = RSW_SEQ_HOLD;
        end else if (s_reg.dly_cnt == DLY_W'(STARTUP_CYC - 1)) begin
          s_next.seq = RSW_SEQ_RUN;
        end else begin
          s_next.dly_cnt = s_reg.dly_cnt + 1'b1;
        end
      end
      default: begin
        if (any_src) begin
          s_next.seq = RSW_SEQ_HOLD;
        end
      end
    endcase
    s_next.sys_reset = (s_next.seq != RSW_SEQ_RUN);
    s_next.irq_req   = s_next.irq_flag & s_next.irq_en & ~always_on_fuse;
    s_next.ew_req    = s_next.ew_flag & s_next.ew_en;

    // avalon slave: one wait cycle, data ready at the accepting edge
    if ((avs_req.read || avs_req.write) && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      s_next.rdata   = 32'h0000_0000;                // unmapped reads zero
      if (avs_req.address == REG_CTRL_OFS) begin
        s_next.rdata[CTL_IRQ_FLAG] = s_reg.irq_flag;
        s_next.rdata[CTL_IRQ_EN]   = irq_eff;
        s_next.rdata[CTL_PRESC3]   = s_reg.presc[3];
        s_next.rdata[CTL_UNLOCK]   = unlock_now;
        s_next.rdata[CTL_SRST_EN]  = srst_eff;
        s_next.rdata[2:0]          = s_reg.presc[2:0];
      end else if (avs_req.address == REG_CKD_OFS) begin
        s_next.rdata[1:0]         = s_reg.div_sel;
        s_next.rdata[CKD_EW_EN]   = s_reg.ew_en;
        s_next.rdata[CKD_EW_FLAG] = s_reg.ew_flag;
      end else if (avs_req.address == REG_FLAG_OFS) begin
        s_next.rdata[5:0] = s_reg.rst_flags;
      end
    end else begin
      s_next.waitreq = 1'b1;
    end

    // synchronous reset: constants only
    if (!rst_n) begin
      s_next           = '0;
      s_next.waitreq   = 1'b1;
      s_next.sys_reset = 1'b1;
      s_next.seq       = RSW_SEQ_HOLD;
      s_next.pin_sy    = 2'b11;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  // outputs straight from flops
  assign avs_rsp.waitrequest = s_reg.waitreq;
  assign avs_rsp.readdata    = s_reg.rdata;
  assign sys_reset_out       = s_reg.sys_reset;
  assign dog_irq             = s_reg.irq_req;
  assign early_irq           = s_reg.ew_req;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_armed;
    unlock_wr ##1 (s_reg.unlock_cnt == UNLOCK_CYC);
  endsequence

  a_dog_pulse_one: assert property (s_reg.dog_pulse |=> !s_reg.dog_pulse)
    else $error("watchdog reset pulse longer than one cycle");
  a_src_resets: assert property (any_src |=> ##1 sys_reset_out)
    else $error("active source did not hold system reset");
  a_stretch_len: assert property (
    (s_reg.seq == RSW_SEQ_RUN) && ($past(s_reg.seq) == RSW_SEQ_STRETCH)
    |-> ($past(s_reg.dly_cnt) == DLY_W'(STARTUP_CYC - 1)))
    else $error("reset released before the startup delay");
  a_window_ends: assert property (
    s_armed ##1 (!unlock_wr)[*3] |=> (s_reg.unlock_cnt == 3'h0))
    else $error("change window did not close after four cycles");
  a_presc_guard: assert property (
    $changed(s_reg.presc) |-> $past(unlock_now) && $past(wr_ctrl))
    else $error("prescale changed outside the window");
  a_div_guard: assert property (
    $changed(s_reg.div_sel) |-> $past(unlock_now) && $past(wr_ckd))
    else $error("divider changed outside the window");
  a_fuse_lock: assert property (always_on_fuse |=> s_reg.srst_en && !s_reg.irq_en)
    else $error("fuse did not lock the enables");
  // stored enable may only drop once the dog flag was already clear
  a_flag_forces: assert property (
    $fell(s_reg.srst_en) |-> !$past(s_reg.rst_flags[FLG_DOG]))
    else $error("reset enable clear while dog flag set");
  a_stopped_clear: assert property (!running |=> (s_reg.dog_cnt == '0))
    else $error("stopped watchdog counter not cleared");
  a_irq_on_expire: assert property (
    (running && expire && !dog_restart && irq_eff && !s_reg.irq_flag)
    |=> s_reg.irq_flag && (dog_irq || !s_reg.irq_en))
    else $error("double timeout did not raise the interrupt");
  a_vector_clear: assert property (
    (dog_vector_ack && s_reg.srst_en && !expire && !wr_ctrl && !unlock_wr)
    |=> !s_reg.irq_en && !s_reg.irq_flag)
    else $error("vector did not drop combined mode");
endmodule : rsw_top
`default_nettype wire

//--- test_reset_sources_and_watchdog.sv
/*
  test_reset_sources_and_watchdog: bus, pin and watchdog checks.
  Assumes rsw_pkg and the design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module test_reset_sources_and_watchdog;
  import rsw_pkg::*;
  logic sys_clk = 0, rst_n = 0, pin_n = 1, osc = 0, alive = 0, restart;
  logic usb_en = 0, usb_opt = 0, usb_rst = 0, bro = 0, bro_en = 0, vec = 0;
  rsw_avs_req_t req = '0;
  rsw_avs_rsp_t rsp;
  logic srst, irq, eirq;
  logic [31:0] q;
  int num_errors = 0, check_count = 0, n;
  always #10 sys_clk = ~sys_clk;
  always #37 osc = ~osc;  // free-running dog oscillator, faster for sim
  rsw_top #(.STARTUP_CYC(20)) rsw_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_req(req), .avs_rsp(rsp), .ext_reset_pin_n(pin_n), .power_on_below(1'b0),
    .brownout_below(bro), .brownout_enable(bro_en), .always_on_fuse(1'b0),
    .osc_128k(osc), .dog_restart(restart), .dog_vector_ack(vec),
    .usb_enable(usb_en), .usb_reset_mcu_en(usb_opt), .usb_bus_reset(usb_rst),
    .sys_reset_out(srst), .dog_irq(irq), .early_irq(eirq));
  rsw_core_model rsw_core_model_inst (.sys_clk(sys_clk), .keep_alive(alive),
    .dog_restart(restart));
  // ----------------------------------------
  // bus access: hold until waitrequest low
  // ----------------------------------------
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 50) num_errors++;
    @(posedge sys_clk);
  endtask : bus
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // wait for a level on srst or irq under a bound
  task wait_for(input logic on_irq, input logic lvl, input int lim);
    n = 0;
    while (((on_irq ? irq : srst) !== lvl) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_for
  task test_done;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    #1800000;
    num_errors++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(srst, 1);
    wait_for(0, 0, 200);
    chk(srst, 0);
    bus(0, 4'hC, 0);
    chk(q, 0);  // unmapped
    $display("test bus done");
    pin_n <= 1'b0;  // short dip, below minimum
    repeat (50) @(posedge sys_clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(srst, 0);
    pin_n <= 1'b0;
    repeat (200) @(posedge sys_clk);
    chk(srst, 1);
    pin_n <= 1'b1;
    wait_for(0, 0, 80);
    chk(srst, 0);
    bus(0, REG_FLAG_OFS, 0);
    chk(q[FLG_EXT], 1);
    $display("test pin done");
    usb_en <= 1'b1;
    usb_rst <= 1'b1;  // option still off: no reset
    repeat (5) @(posedge sys_clk);
    chk(srst, 0);
    usb_opt <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(srst, 1);
    usb_rst <= 1'b0;
    wait_for(0, 0, 80);
    chk(srst, 0);
    bro_en <= 1'b1;
    bro <= 1'b1;  // dip shorter than minimum
    repeat (50) @(posedge sys_clk);
    bro <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(srst, 0);
    bro <= 1'b1;
    repeat (150) @(posedge sys_clk);
    chk(srst, 1);
    bro <= 1'b0;
    wait_for(0, 0, 80);
    chk(srst, 0);
    bus(0, REG_FLAG_OFS, 0);
    chk(q, 32'h26);
    $display("test sources done");
    bus(1, REG_CTRL_OFS, 32'h47);
    bus(0, REG_CTRL_OFS, 0);
    chk(q, 32'h40);
    bus(1, REG_CKD_OFS, 32'h5);
    bus(0, REG_CKD_OFS, 0);
    chk(q, 32'h4);
    bus(1, REG_CTRL_OFS, 32'h18);
    bus(1, REG_CKD_OFS, 32'h6);
    bus(0, REG_CKD_OFS, 0);
    chk(q, 32'h6);
    bus(0, REG_CTRL_OFS, 0);
    chk(q, 32'h08);
    bus(1, REG_CTRL_OFS, 32'h18);
    bus(1, REG_CKD_OFS, 32'h4);
    bus(1, REG_CTRL_OFS, 32'h18);
    bus(1, REG_CTRL_OFS, 32'h41);
    bus(1, REG_CTRL_OFS, 32'h40);
    bus(0, REG_CTRL_OFS, 0);
    chk(q, 32'h41);
    alive <= 1'b1;
    repeat (32000) @(posedge sys_clk);
    chk(irq, 0);
    chk(eirq, 0);
    alive <= 1'b0;
    wait_for(1, 1, 32000);
    chk(irq, 1);
    chk(eirq, 1);
    chk(srst, 0);
    bus(1, REG_CTRL_OFS, 32'hC1);
    chk(irq, 0);
    vec <= 1'b1;  // vector in interrupt-only mode
    @(posedge sys_clk);
    vec <= 1'b0;
    bus(0, REG_CTRL_OFS, 0);
    chk(q, 32'h41);
    $display("test dog done");
    test_done();
  end
endmodule : test_reset_sources_and_watchdog
`default_nettype wire
